// [rstc_regs.svh]
// Register map, field positions, reset values and timing counts of the reset controller.
// Assumes a 32-bit classic Wishbone slave with byte addresses on an 8-bit address.
// Notes on behaviour
// - Status bits 10:8 hold last reset cause: 0 power, 1 backup, 2 watchdog, 3 software, 4 pin.
// - Reading status leaves the reset cause field untouched.
// - Status bit 17 is high while a software reset runs, clears itself after.
// - Status bit 16 shows the reset pin level, resampled every rising main clock edge.
// - Status bit 0 sets on a pin falling edge and holds until status is read.
// - Interrupt while pin fall flag set, pin reset disabled and mode bit 4 set.
// - A status read clears the pin fall flag and its interrupt.
// - Command and mode writes need key 0xA5 in bits 31:24; key reads zero.
// - Command bit 0 with good key resets the processor; zero does nothing.
// - Command bit 2 with good key resets the peripherals; zero does nothing.
// - Command bit 3 drives the pin low and resets processor and peripherals.
// - Mode bit 0 set lets a low pin level start a pin reset.
// - Pin pulse lasts two to the power of length plus one slow clock cycles.
// - A software reset lasts three slow clock cycles.
// - Command writes are ignored while a software reset is in progress.
// - The cause field updates when the processor reset is released, except after a command with bit 3 set and bit 0 clear.
`ifndef RSTC_REGS_SVH
`define RSTC_REGS_SVH

// ------------------------------------------------------------
// Offsets
// ------------------------------------------------------------
`define RSTC_OFF_CMD 8'h00
`define RSTC_OFF_STATUS 8'h04
`define RSTC_OFF_MODE 8'h08
`define RSTC_OFF_IRQ_STATUS 8'h0C
`define RSTC_OFF_IRQ_MASK 8'h10

// ------------------------------------------------------------
// Fields
// ------------------------------------------------------------
`define RSTC_KEY_MSB 31
`define RSTC_KEY_LSB 24
`define RSTC_KEY_VALUE 8'hA5
`define RSTC_CMD_CPU 0
`define RSTC_CMD_PERIPH 2
`define RSTC_CMD_PIN 3
`define RSTC_ST_FALL 0
`define RSTC_ST_CAUSE_LSB 8
`define RSTC_ST_LEVEL 16
`define RSTC_ST_BUSY 17
`define RSTC_MODE_EN 0
`define RSTC_MODE_IEN 4
`define RSTC_MODE_LEN_LSB 8
`define RSTC_IRQ_PIN_FALL 0
`define RSTC_IRQ_SW_DONE 1

// ------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------
`define RSTC_MODE_EN_RESET 1'b1
`define RSTC_MODE_IEN_RESET 1'b0
`define RSTC_MODE_LEN_RESET 4'h0
`define RSTC_SW_RESET_SLOW_CYCLES 2'h3
`define RSTC_USER_EXIT_SLOW_CYCLES 2'h3

`endif

// [rstc_pkg.sv]
// Types shared by the reset controller modules.
// Assumes rstc_regs.svh supplies the numeric constants.
package rstc_pkg;
  typedef enum logic [2:0]
  {
    CAUSE_GENERAL,
    CAUSE_BACKUP,
    CAUSE_WATCHDOG,
    CAUSE_SOFTWARE,
    CAUSE_USER
  } rstc_cause_t;

  typedef enum logic [1:0]
  {
    ST_RUN,
    ST_SOFT,
    ST_WDOG,
    ST_USER
  } rstc_state_t;
endpackage

// [rstc_pin_sampler.sv]
// Samples the external reset pin and flags its falling edges.
// Assumes the pin input is already synchronous to clk_i.
`timescale 1ns/100ps
module rstc_pin_sampler
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pin
  input wire logic pin_i,
  // Results
  output logic level_o,
  output logic fall_o
);
  logic level_reg;
  logic level_next;
  logic fall_reg;
  logic fall_next;

  always_comb
  begin
    level_next = pin_i;
    fall_next = level_reg & ~pin_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      level_reg <= 1'b1;
      fall_reg <= 1'b0;
    end
    else
    begin
      level_reg <= level_next;
      fall_reg <= fall_next;
    end
  end

  assign level_o = level_reg;
  assign fall_o = fall_reg;
endmodule

// [rstc_pulse_timer.sv]
// Times the low pulse driven onto the external reset pin in slow clock ticks.
// Assumes tick_i is a one-cycle pulse per slow clock period.
`timescale 1ns/100ps
module rstc_pulse_timer
#(
  parameter int LEN_W = 4,
  parameter int CNT_W = 17
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic start_i,
  input wire logic tick_i,
  input wire logic [LEN_W-1:0] len_i,
  // Status
  output logic busy_o
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic busy_reg;
  logic busy_next;

  always_comb
  begin
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    if (start_i)
    begin
      // Shift amount is one bit wider than the field so that length 15 does not wrap
      cnt_next = CNT_W'(1) << ({1'b0, len_i} + 1'b1);
      busy_next = 1'b1;
    end
    else if (busy_reg && tick_i)
    begin
      cnt_next = cnt_reg - 1'b1;
      busy_next = (cnt_reg != CNT_W'(1));
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
    end
  end

  assign busy_o = busy_reg;
endmodule

// [rstc_top.sv]
// Reset controller: Wishbone registers, reset sequencing, pin manager and interrupt.
// Assumes a slow clock level on slow_clk_i synchronous to clk_i and an open-drain pin.
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "rstc_regs.svh"
module rstc_top
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Reset sources
  input wire logic slow_clk_i,
  input wire logic backup_reset_i,
  input wire logic watchdog_fault_i,
  // External reset pin
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe_o,
  // Reset outputs
  output logic cpu_reset_o,
  output logic periph_reset_o,
  // Interrupt
  output logic irq_o
);
  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  rstc_pkg::rstc_state_t state_reg, state_next;
  rstc_pkg::rstc_cause_t cause_reg, cause_next;
  logic [1:0] slow_cnt_reg, slow_cnt_next;
  logic slow_prev_reg, slow_tick;
  logic cpu_rst_reg, cpu_rst_next;
  logic per_rst_reg, per_rst_next;
  logic sw_cpu_reg, sw_cpu_next;
  logic start_reg, start_next;
  logic boot_reg;
  logic pulse_prev_reg;
  logic pin_level, pin_fall, pulse_busy;
  logic fall_seen_reg, fall_seen_next;
  logic mode_en_reg, mode_en_next;
  logic mode_ien_reg, mode_ien_next;
  logic [3:0] mode_len_reg, mode_len_next;
  logic [1:0] irq_st_reg, irq_st_next;
  logic [1:0] irq_mask_reg, irq_mask_next;
  logic irq_reg, irq_next;
  logic ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  logic access, wr, rd_status, cmd_ok, sw_done;

  // Key check is shared by the command and mode writes
  function automatic logic key_ok(input logic [31:0] d);
    key_ok = (d[`RSTC_KEY_MSB:`RSTC_KEY_LSB] == `RSTC_KEY_VALUE);
  endfunction

  // ------------------------------------------------------------
  // Pin manager
  // ------------------------------------------------------------
  rstc_pin_sampler u_sampler
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(pin_i),
    .level_o(pin_level),
    .fall_o(pin_fall)
  );

  rstc_pulse_timer #(.LEN_W(4), .CNT_W(17)) u_pulse
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(start_reg),
    .tick_i(slow_tick),
    .len_i(mode_len_reg),
    .busy_o(pulse_busy)
  );

  assign slow_tick = slow_clk_i & ~slow_prev_reg;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  // Only full-word writes are honoured, so the key lane is always present
  assign access = cyc_i & stb_i & ~ack_reg;
  assign wr = access & we_i & (sel_i == 4'hF);
  assign rd_status = access & ~we_i & (adr_i == `RSTC_OFF_STATUS);
  assign cmd_ok = wr && (adr_i == `RSTC_OFF_CMD) && key_ok(dat_i)
    && (state_reg == rstc_pkg::ST_RUN)
    && (dat_i[`RSTC_CMD_CPU] | dat_i[`RSTC_CMD_PERIPH] | dat_i[`RSTC_CMD_PIN]);

  always_comb
  begin
    ack_next = access;
    dat_next = 32'h0000_0000;
    if (access && !we_i)
    begin
      unique case (adr_i)
        `RSTC_OFF_STATUS:
        begin
          dat_next[`RSTC_ST_FALL] = fall_seen_reg;
          dat_next[`RSTC_ST_CAUSE_LSB +: 3] = cause_reg;
          dat_next[`RSTC_ST_LEVEL] = pin_level;
          dat_next[`RSTC_ST_BUSY] = (state_reg == rstc_pkg::ST_SOFT);
        end
        `RSTC_OFF_MODE:
        begin
          dat_next[`RSTC_MODE_EN] = mode_en_reg;
          dat_next[`RSTC_MODE_IEN] = mode_ien_reg;
          dat_next[`RSTC_MODE_LEN_LSB +: 4] = mode_len_reg;
        end
        `RSTC_OFF_IRQ_STATUS:
        begin
          dat_next[1:0] = irq_st_reg;
        end
        `RSTC_OFF_IRQ_MASK:
        begin
          dat_next[1:0] = irq_mask_reg;
        end
        default:
        begin
          dat_next = 32'h0000_0000;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Registers written by software
  // ------------------------------------------------------------
  always_comb
  begin
    mode_en_next = mode_en_reg;
    mode_ien_next = mode_ien_reg;
    mode_len_next = mode_len_reg;
    irq_mask_next = irq_mask_reg;
    if (wr && (adr_i == `RSTC_OFF_MODE) && key_ok(dat_i))
    begin
      mode_en_next = dat_i[`RSTC_MODE_EN];
      mode_ien_next = dat_i[`RSTC_MODE_IEN];
      mode_len_next = dat_i[`RSTC_MODE_LEN_LSB +: 4];
    end
    if (wr && (adr_i == `RSTC_OFF_IRQ_MASK))
    begin
      irq_mask_next = dat_i[1:0];
    end
  end

  // ------------------------------------------------------------
  // Reset sequencer
  // ------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    cause_next = cause_reg;
    slow_cnt_next = slow_cnt_reg;
    cpu_rst_next = cpu_rst_reg;
    per_rst_next = per_rst_reg;
    sw_cpu_next = sw_cpu_reg;
    start_next = boot_reg;
    sw_done = 1'b0;
    if (backup_reset_i)
    begin
      state_next = rstc_pkg::ST_RUN;
      cause_next = rstc_pkg::CAUSE_BACKUP;
      cpu_rst_next = 1'b0;
      per_rst_next = 1'b0;
    end
    else if (watchdog_fault_i && (state_reg != rstc_pkg::ST_WDOG))
    begin
      // Watchdog wins over a software reset in progress
      state_next = rstc_pkg::ST_WDOG;
      slow_cnt_next = 2'h0;
      cpu_rst_next = 1'b1;
      per_rst_next = 1'b1;
      start_next = 1'b1;
    end
    else
    begin
      unique case (state_reg)
        rstc_pkg::ST_RUN:
        begin
          if (cmd_ok)
          begin
            state_next = rstc_pkg::ST_SOFT;
            slow_cnt_next = 2'h0;
            cpu_rst_next = dat_i[`RSTC_CMD_CPU] | dat_i[`RSTC_CMD_PIN];
            per_rst_next = dat_i[`RSTC_CMD_PERIPH] | dat_i[`RSTC_CMD_PIN];
            sw_cpu_next = dat_i[`RSTC_CMD_CPU];
            start_next = dat_i[`RSTC_CMD_PIN];
          end
          // Sampled level lags the end of our own pulse by one cycle, so wait for it
          else if (!pin_level && mode_en_reg && !pulse_busy && !pulse_prev_reg)
          begin
            state_next = rstc_pkg::ST_USER;
            slow_cnt_next = 2'h0;
            cpu_rst_next = 1'b1;
            per_rst_next = 1'b1;
          end
        end
        rstc_pkg::ST_SOFT, rstc_pkg::ST_WDOG:
        begin
          if (slow_tick)
          begin
            slow_cnt_next = slow_cnt_reg + 2'h1;
            if (slow_cnt_reg == `RSTC_SW_RESET_SLOW_CYCLES - 2'h1)
            begin
              state_next = rstc_pkg::ST_RUN;
              cpu_rst_next = 1'b0;
              per_rst_next = 1'b0;
              if (state_reg == rstc_pkg::ST_WDOG)
              begin
                cause_next = rstc_pkg::CAUSE_WATCHDOG;
              end
              else
              begin
                sw_done = 1'b1;
                if (sw_cpu_reg)
                begin
                  cause_next = rstc_pkg::CAUSE_SOFTWARE;
                end
              end
            end
          end
        end
        rstc_pkg::ST_USER:
        begin
          if (!pin_level)
          begin
            slow_cnt_next = 2'h0;
          end
          else if (slow_tick)
          begin
            slow_cnt_next = slow_cnt_reg + 2'h1;
            if (slow_cnt_reg == `RSTC_USER_EXIT_SLOW_CYCLES - 2'h1)
            begin
              state_next = rstc_pkg::ST_RUN;
              cpu_rst_next = 1'b0;
              per_rst_next = 1'b0;
              cause_next = rstc_pkg::CAUSE_USER;
            end
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Status flags and interrupt
  // ------------------------------------------------------------
  always_comb
  begin
    // A fall in the same cycle as the read is kept: set wins over clear
    fall_seen_next = pin_fall | (fall_seen_reg & ~rd_status);
    irq_st_next = irq_st_reg;
    if (wr && (adr_i == `RSTC_OFF_IRQ_STATUS))
    begin
      irq_st_next = irq_st_reg & ~dat_i[1:0];
    end
    irq_st_next[`RSTC_IRQ_PIN_FALL] = irq_st_next[`RSTC_IRQ_PIN_FALL] | pin_fall;
    irq_st_next[`RSTC_IRQ_SW_DONE] = irq_st_next[`RSTC_IRQ_SW_DONE] | sw_done;
    irq_next = (fall_seen_next & ~mode_en_reg & mode_ien_reg)
      | (|(irq_st_reg & irq_mask_reg));
  end

  // ------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= rstc_pkg::ST_RUN;
      cause_reg <= rstc_pkg::CAUSE_GENERAL;
      slow_cnt_reg <= 2'h0;
      slow_prev_reg <= 1'b0;
      cpu_rst_reg <= 1'b0;
      per_rst_reg <= 1'b0;
      sw_cpu_reg <= 1'b0;
      start_reg <= 1'b0;
      boot_reg <= 1'b1;
      pulse_prev_reg <= 1'b0;
      fall_seen_reg <= 1'b0;
      mode_en_reg <= `RSTC_MODE_EN_RESET;
      mode_ien_reg <= `RSTC_MODE_IEN_RESET;
      mode_len_reg <= `RSTC_MODE_LEN_RESET;
      irq_st_reg <= 2'h0;
      irq_mask_reg <= 2'h0;
      irq_reg <= 1'b0;
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end
    else
    begin
      state_reg <= state_next;
      cause_reg <= cause_next;
      slow_cnt_reg <= slow_cnt_next;
      slow_prev_reg <= slow_clk_i;
      cpu_rst_reg <= cpu_rst_next;
      per_rst_reg <= per_rst_next;
      sw_cpu_reg <= sw_cpu_next;
      start_reg <= start_next;
      boot_reg <= 1'b0;
      pulse_prev_reg <= pulse_busy;
      fall_seen_reg <= fall_seen_next;
      mode_en_reg <= mode_en_next;
      mode_ien_reg <= mode_ien_next;
      mode_len_reg <= mode_len_next;
      irq_st_reg <= irq_st_next;
      irq_mask_reg <= irq_mask_next;
      irq_reg <= irq_next;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign dat_o = dat_reg;
  assign ack_o = ack_reg;
  assign pin_o = 1'b0;
  assign pin_oe_o = pulse_busy;
  assign cpu_reset_o = cpu_rst_reg;
  assign periph_reset_o = per_rst_reg;
  assign irq_o = irq_reg;
endmodule

// [rstc_board_model.sv]
// Board side of the reset pin: pull-up, push button, open-drain driver.
// Assumes the device sinks the line only while pin_oe_o is high.
`timescale 1ns/100ps
module rstc_board_model
(
  // Device drive
  input wire logic pin_o,
  input wire logic pin_oe_o,
  // Push button, high while pressed
  input wire logic press_i,
  // Wire level
  output logic wire_o
);
  // Pull-up wins unless a party sinks the line, so a released pin reads one
  assign wire_o = ((pin_oe_o & !pin_o) | press_i) ? 1'b0 : 1'b1;
endmodule

// [rstc_checker.sv]
// Port assertions for the reset controller.
// Assumes a classic Wishbone master that holds its request until ack.
`timescale 1ns/100ps
module rstc_checker
(
  // Observed ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic backup_reset_i,
  input wire logic watchdog_fault_i,
  input wire logic pin_i,
  input wire logic pin_oe_o,
  input wire logic cpu_reset_o,
  input wire logic periph_reset_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ------------------------------------------------------------
  // Shadow of mode enables and mask, kept from bus writes
  // ------------------------------------------------------------
  logic tk;
  logic idle;
  logic [2:0] shd_reg;
  logic [2:0] shd_next;
  assign tk = cyc_i & stb_i & !ack_o & (sel_i == 4'hF);
  assign idle = !cpu_reset_o & !periph_reset_o & !pin_oe_o & pin_i & !watchdog_fault_i
    & !backup_reset_i;
  always_comb
  begin
    shd_next = shd_reg;
    if (tk && we_i && adr_i == 8'h08 && dat_i[31:24] == 8'hA5)
      shd_next[1:0] = {dat_i[4], dat_i[0]};
    if (tk && we_i && adr_i == 8'h10)
      shd_next[2] = |dat_i[1:0];
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      shd_reg <= 3'h1;
    else
      shd_reg <= shd_next;
  end
  sequence cmd(c);
    tk && we_i && adr_i == 8'h00 && dat_i == c && idle;
  endsequence
  // No pin change in flight, so the flag pipeline has settled
  sequence steady_rd;
    $stable(pin_i)[*3] ##0 tk && !we_i && adr_i == 8'h04;
  endsequence
  a_cpu_cmd: assert property (cmd(32'hA500_0001) |=> cpu_reset_o && !periph_reset_o)
    else $error("cpu command did not reset the processor alone");
  a_periph_cmd: assert property (cmd(32'hA500_0004) |=>
    periph_reset_o && !cpu_reset_o)
    else $error("peripheral command wrong reset lines");
  a_pin_cmd: assert property (cmd(32'hA500_0008) |=>
    cpu_reset_o && periph_reset_o ##[0:2] pin_oe_o)
    else $error("pin command did not drive the pin");
  a_bad_key: assert property (tk && we_i && adr_i == 8'h00
    && dat_i[31:24] != 8'hA5 && idle && $past(pin_i) |=> !cpu_reset_o && !periph_reset_o)
    else $error("command with wrong key took effect");
  a_sw_span: assert property (cmd(32'hA500_0001) |=>
    cpu_reset_o[*8] ##[1:40] !cpu_reset_o)
    else $error("software reset span out of range");
  a_mode_rsvd: assert property (ack_o && !we_i && adr_i == 8'h08 |->
    dat_o[31:12] == 20'h0 && dat_o[7:5] == 3'h0 && dat_o[3:1] == 3'h0)
    else $error("mode key or reserved bits not zero");
  a_status_rsvd: assert property (ack_o && !we_i && adr_i == 8'h04 |->
    dat_o[31:18] == 14'h0 && dat_o[15:11] == 5'h0 && dat_o[7:1] == 7'h0)
    else $error("status reserved bits not zero");
  a_level_bit: assert property (steady_rd |=> dat_o[16] == $past(pin_i))
    else $error("status pin level wrong");
  a_irq_fall: assert property ($fell(pin_i) && shd_reg[1:0] == 2'h2 |->
    ##[1:6] irq_o)
    else $error("pin fall gave no interrupt");
  a_irq_clear: assert property (steady_rd ##0 !shd_reg[2] |=> ##1 !irq_o)
    else $error("status read left interrupt up");
endmodule

bind rstc_top rstc_checker u_chk
(
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .backup_reset_i(backup_reset_i), .watchdog_fault_i(watchdog_fault_i), .pin_i(pin_i),
  .pin_oe_o(pin_oe_o), .cpu_reset_o(cpu_reset_o), .periph_reset_o(periph_reset_o),
  .irq_o(irq_o)
);

// [tb_top.sv]
// Self-checking bench for the reset controller registers, pin resets, software resets and reset causes.
// Assumes the board model closes the loop on the reset pin.
`timescale 1ns/100ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0000_0000;
  logic slow_clk_i = 1'b0;
  logic backup_reset_i = 1'b0;
  logic watchdog_fault_i = 1'b0;
  logic press = 1'b0;
  logic [2:0] slow_cnt = 3'h0;
  logic [31:0] dat_o, rd;
  logic ack_o, pin_w, pin_o, pin_oe_o, cpu_reset_o, periph_reset_o, irq_o;
  logic [2:0] cause;
  logic [11:0] modes [3] = '{12'h110, 12'h100, 12'h111};
  logic [3:0] cmds [3] = '{4'h4, 4'h1, 4'h8};
  logic [2:0] lines [3] = '{3'h2, 3'h4, 3'h7};
  int miscompares = 0;
  int n_compared = 0;
  int hi_cnt = 0;
  int c;
  always #25 clk_i = ~clk_i;
  // Slow clock is eight main clocks so that tick counts stay short
  always @(posedge clk_i)
  begin
    slow_cnt <= slow_cnt + 3'h1;
    slow_clk_i <= slow_cnt[2];
    hi_cnt <= (cpu_reset_o | periph_reset_o | pin_oe_o) ? hi_cnt + 1 : 0;
  end
  rstc_board_model u_board (.pin_o(pin_o), .pin_oe_o(pin_oe_o), .press_i(press), .wire_o(pin_w));
  rstc_top u_dut
  (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .slow_clk_i(slow_clk_i),
    .backup_reset_i(backup_reset_i), .watchdog_fault_i(watchdog_fault_i), .pin_i(pin_w),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o), .cpu_reset_o(cpu_reset_o),
    .periph_reset_o(periph_reset_o), .irq_o(irq_o)
  );
  // ------------------------------------------------------------
  // Bus and compare helpers
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1 && t < 50)
    begin
      t++;
      @(posedge clk_i);
    end
    if (t == 50)
      miscompares++;
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(what, exp, rd);
  endtask
  task automatic span(output int n);
    n = 0;
    for (int k = 0; k < 300 && (cpu_reset_o | periph_reset_o | pin_oe_o) === 1'b1; k++)
    begin
      n = hi_cnt;
      @(posedge clk_i);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (60) @(posedge clk_i);
    rdchk("powerup fall", 8'h04, 32'h0001_0001);
    rdchk("status", 8'h04, 32'h0001_0000);
    rdchk("mode reset", 8'h08, 32'h0000_0001);
    rdchk("unmapped", 8'h14, 32'h0000_0000);
    bus(1'b1, 8'h08, 32'h5A00_0011);
    rdchk("mode bad key", 8'h08, 32'h0000_0001);
    bus(1'b1, 8'h08, 32'hA5FF_FFFF);
    rdchk("mode reserved", 8'h08, 32'h0000_0F11);
    bus(1'b1, 8'h0C, 32'h0000_0003);
    $display("test registers done");
    foreach (modes[i])
    begin
      bus(1'b1, 8'h08, {20'hA5000, modes[i]});
      press <= 1'b1;
      repeat (6) @(posedge clk_i);
      check("irq", {31'h0, modes[i] == 12'h110}, {31'h0, irq_o});
      check("user reset", {31'h0, modes[i][0]}, {31'h0, cpu_reset_o});
      rdchk("status low", 8'h04, 32'h0000_0001);
      repeat (3) @(posedge clk_i);
      check("irq cleared", 32'h0, {31'h0, irq_o});
      press <= 1'b0;
      repeat (40) @(posedge clk_i);
      rdchk("cause", 8'h04,
        modes[i][0] ? 32'h0001_0400 : 32'h0001_0000);
      rdchk("cause kept", 8'h04,
        modes[i][0] ? 32'h0001_0400 : 32'h0001_0000);
    end
    check("irq masked", 32'h0, {31'h0, irq_o});
    bus(1'b1, 8'h10, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    check("irq unmasked", 32'h1, {31'h0, irq_o});
    bus(1'b1, 8'h0C, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    check("irq w1c", 32'h0, {31'h0, irq_o});
    rdchk("irq status", 8'h0C, 32'h0000_0000);
    bus(1'b1, 8'h10, 32'h0000_0000);
    $display("test pin done");
    bus(1'b1, 8'h08, 32'hA500_0100);
    bus(1'b1, 8'h00, 32'hA500_0000);
    bus(1'b1, 8'h00, 32'h5A00_0001);
    check("no reset", 32'h0, {30'h0, cpu_reset_o, periph_reset_o});
    cause = 3'h4;
    foreach (cmds[i])
    begin
      bus(1'b1, 8'h00, {28'hA50_0000, cmds[i]});
      bus(1'b0, 8'h04, 32'h0000_0000);
      check("busy", {14'h0, 1'b1, 6'h0, cause, 8'h0},
        {14'h0, rd[17], 6'h0, rd[10:8], 8'h0});
      bus(1'b1, 8'h00, 32'hA500_000C);
      check("lines", {29'h0, lines[i]},
        {29'h0, cpu_reset_o, periph_reset_o, pin_oe_o});
      check("pin drive", 32'h0, {31'h0, pin_o});
      span(c);
      check("span", 32'h1,
        (cmds[i] == 4'h8) ? (c >= 24 && c <= 36) : (c >= 16 && c <= 26));
      cause = (cmds[i] == 4'h1) ? 3'h3 : cause;
      bus(1'b0, 8'h04, 32'h0000_0000);
      check("done", {21'h0, cause, 8'h0},
        {14'h0, rd[17], 6'h0, rd[10:8], 8'h0});
    end
    $display("test software done");
    backup_reset_i <= 1'b1;
    @(posedge clk_i);
    backup_reset_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    bus(1'b0, 8'h04, 32'h0000_0000);
    check("backup cause", 32'h1, {29'h0, rd[10:8]});
    watchdog_fault_i <= 1'b1;
    @(posedge clk_i);
    watchdog_fault_i <= 1'b0;
    @(posedge clk_i);
    span(c);
    bus(1'b0, 8'h04, 32'h0000_0000);
    check("watchdog cause", 32'h2, {29'h0, rd[10:8]});
    $display("test causes done");
    tally_and_finish;
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    tally_and_finish;
  end
endmodule
